// *** hdl/twi_slave_tx.sv ***
// two-wire slave transmitter core with status codes and bus error recovery
// assumes pins are open drain (oe high pulls low) and a same-clock register port
`timescale 1ns/1ps
module twi_slave_tx
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // from master logic, same clock
  input  wire logic       arb_lost_i,
  // bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // interrupt
  output logic            irq_o
);
  // ***********************************
  // state
  // ***********************************
  twi_st_pkg::st_t st_q, st_d;        // core state
  logic [7:0] ctrl_q;                 // control bits except the flag
  logic       flag_q, flag_d;         // operation complete
  logic [7:0] code_q, code_d;         // last status code
  logic [7:0] data_q;                 // byte to send
  logic [7:0] own_q;                  // own address and gce
  logic [7:0] sh_q, sh_d;             // shift register
  logic [3:0] cnt_q, cnt_d;           // bit counter
  logic [7:0] tmr_q, tmr_d;           // start hold timer
  logic       sda_dr_q, sda_dr_d;     // drive data low
  logic       scl_dr_q;               // drive clock low
  logic       last_q, last_d;         // final byte in flight
  logic       ack_q, ack_d;           // master acked
  logic       pend_q, pend_d;         // start waiting for free bus
  logic       busy_q;                 // bus between start and stop
  logic       arb_q;                  // arbitration was lost
  logic [twi_st_pkg::EV_W-1:0] evt_q, evt_d;   // sticky events
  logic [twi_st_pkg::EV_W-1:0] mask_q;         // event mask
  logic [7:0] rdata_q;                // read data
  logic       irq_q;                  // interrupt level
  logic       flag_set;               // hardware raises flag
  logic       stop_clr;               // recovery clears stop bit
  bus_evt_if  ev ();                  // line events

  // ***********************************
  // line front end
  // ***********************************
  line_sync u_sync
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .lines     (ev)
  );
  line_detect u_det
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .ev        (ev)
  );

  // ***********************************
  // register decode
  // ***********************************
  wire wr_ctrl  = reg_wr_i & (reg_addr_i == twi_st_pkg::A_CTRL);
  wire wr_data  = reg_wr_i & (reg_addr_i == twi_st_pkg::A_DATA);
  wire wr_own   = reg_wr_i & (reg_addr_i == twi_st_pkg::A_OWN);
  wire wr_evt   = reg_wr_i & (reg_addr_i == twi_st_pkg::A_EVT);
  wire wr_mask  = reg_wr_i & (reg_addr_i == twi_st_pkg::A_MASK);
  // writing one to the flag clears it and lets the core go on
  wire flag_clr = wr_ctrl & reg_wdata_i[twi_st_pkg::CB_FLAG];
  wire acken    = ctrl_q[twi_st_pkg::CB_ACKEN];
  wire enable   = ctrl_q[twi_st_pkg::CB_EN];
  // status shows a code only while the flag is up
  wire [7:0] sts_rd = flag_q ? (code_q & twi_st_pkg::PRESC_MASK)
                             : twi_st_pkg::ST_NO_INFO;
  wire [7:0] rd_mux;
  assign rd_mux =
    (reg_addr_i == twi_st_pkg::A_CTRL) ? {flag_q, ctrl_q[6:0]} :
    (reg_addr_i == twi_st_pkg::A_STS)  ? sts_rd :
    (reg_addr_i == twi_st_pkg::A_DATA) ? data_q :
    (reg_addr_i == twi_st_pkg::A_OWN)  ? own_q :
    (reg_addr_i == twi_st_pkg::A_EVT)  ? {6'h00, evt_q} :
    (reg_addr_i == twi_st_pkg::A_MASK) ? {6'h00, mask_q} : 8'h00;
  // own address in upper seven bits, read direction in bit 0
  wire addr_hit = (sh_q[7:1] == own_q[7:1]) & sh_q[0] & acken;
  // start or stop inside a byte or acknowledge slot
  wire in_frame = ((st_q == twi_st_pkg::S_ADDR) & (cnt_q != 4'h0)) |
                  (st_q == twi_st_pkg::S_AACK) | (st_q == twi_st_pkg::S_TX) |
                  (st_q == twi_st_pkg::S_TACK);
  wire frame_err = enable & (ev.start | ev.stop) & in_frame;

  // ***********************************
  // next state
  // ***********************************
  always_comb
  begin
    st_d     = st_q;
    code_d   = code_q;
    sh_d     = sh_q;
    cnt_d    = cnt_q;
    tmr_d    = tmr_q;
    sda_dr_d = sda_dr_q;
    last_d   = last_q;
    ack_d    = ack_q;
    pend_d   = pend_q;
    flag_set = 1'b0;
    stop_clr = 1'b0;
    if (!enable)
    begin
      // switched off: release everything
      st_d     = twi_st_pkg::S_IDLE;
      sda_dr_d = 1'b0;
    end
    else if (frame_err)
    begin
      // lines released, flag up with the error code
      st_d     = twi_st_pkg::S_BERR;
      sda_dr_d = 1'b0;
      flag_set = 1'b1;
      code_d   = twi_st_pkg::ST_BUS_ERR;
    end
    else
    begin
      case (st_q)
        twi_st_pkg::S_IDLE:
        begin
          if (ev.start)
          begin
            st_d  = twi_st_pkg::S_ADDR;
            cnt_d = 4'h0;
          end
          else if (pend_q && !busy_q)
          begin
            // bus free: pull data low while clock is high
            st_d     = twi_st_pkg::S_GEN;
            tmr_d    = 8'h00;
            sda_dr_d = 1'b1;
            pend_d   = 1'b0;
          end
        end
        twi_st_pkg::S_ADDR:
        begin
          if (ev.stop)
            st_d = twi_st_pkg::S_IDLE;
          else if (ev.start)
            cnt_d = 4'h0;
          else if (ev.scl_rise)
          begin
            sh_d  = {sh_q[6:0], ev.sda};
            cnt_d = cnt_q + 4'h1;
          end
          else if (ev.scl_fall && cnt_q == twi_st_pkg::BITS)
          begin
            // general call is a write, so it never reaches here
            st_d     = addr_hit ? twi_st_pkg::S_AACK : twi_st_pkg::S_IDLE;
            sda_dr_d = addr_hit;
          end
        end
        twi_st_pkg::S_AACK:
        begin
          if (ev.scl_fall)
          begin
            sda_dr_d = 1'b0;
            flag_set = 1'b1;
            st_d     = twi_st_pkg::S_HOLD;
            code_d   = arb_q ? twi_st_pkg::ST_ARB_READ
                             : twi_st_pkg::ST_OWN_READ;
          end
        end
        twi_st_pkg::S_HOLD:
        begin
          if (flag_clr)
          begin
            if (code_q == twi_st_pkg::ST_DATA_NACK || code_q == twi_st_pkg::ST_LAST_ACK)
            begin
              // back to not addressed; ack enable gates the next match
              // sda stays released, so a master reading on gets ones
              st_d   = twi_st_pkg::S_IDLE;
              pend_d = reg_wdata_i[twi_st_pkg::CB_START];
            end
            else
            begin
              // load the next byte; ack enable 0 makes it the last
              sh_d     = data_q;
              last_d   = ~reg_wdata_i[twi_st_pkg::CB_ACKEN];
              cnt_d    = 4'h0;
              sda_dr_d = ~data_q[7];
              st_d     = twi_st_pkg::S_TX;
            end
          end
        end
        twi_st_pkg::S_TX:
        begin
          if (ev.scl_fall)
          begin
            // data only moves while the clock is low
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == twi_st_pkg::BITS - 4'h1)
            begin
              sda_dr_d = 1'b0;
              st_d     = twi_st_pkg::S_TACK;
            end
            else
            begin
              sh_d     = {sh_q[6:0], 1'b0};
              sda_dr_d = ~sh_q[6];
            end
          end
        end
        twi_st_pkg::S_TACK:
        begin
          if (ev.scl_rise)
            ack_d = ~ev.sda;
          else if (ev.scl_fall)
          begin
            flag_set = 1'b1;
            st_d     = twi_st_pkg::S_HOLD;
            if (!ack_q)
              code_d = twi_st_pkg::ST_DATA_NACK;
            else if (last_q)
              code_d = twi_st_pkg::ST_LAST_ACK;
            else
              code_d = twi_st_pkg::ST_DATA_ACK;
          end
        end
        twi_st_pkg::S_BERR:
        begin
          if (flag_clr && reg_wdata_i[twi_st_pkg::CB_STOP])
          begin
            // only internal state resets, no stop on the bus
            st_d     = twi_st_pkg::S_IDLE;
            stop_clr = 1'b1;
          end
        end
        twi_st_pkg::S_GEN:
        begin
          tmr_d = tmr_q + 8'h01;
          if (tmr_q == twi_st_pkg::HD_STA_CYC)
            st_d = twi_st_pkg::S_MST;
        end
        default:
        begin
          // master phase is outside this core: hold until start bit cleared
          if (!ctrl_q[twi_st_pkg::CB_START])
          begin
            st_d     = twi_st_pkg::S_IDLE;
            sda_dr_d = 1'b0;
          end
        end
      endcase
    end
  end

  // set wins over a clear arriving in the same cycle
  assign flag_d = flag_set | (flag_q & ~flag_clr);
  assign evt_d  = (evt_q & ~(wr_evt ? reg_wdata_i[1:0] : 2'h0)) |
                  {frame_err, flag_set};

  // ***********************************
  // core registers
  // ***********************************
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_q     <= twi_st_pkg::S_IDLE;
      flag_q   <= 1'b0;
      code_q   <= twi_st_pkg::ST_NO_INFO;
      sh_q     <= 8'h00;
      cnt_q    <= 4'h0;
      tmr_q    <= 8'h00;
      sda_dr_q <= 1'b0;
      scl_dr_q <= 1'b0;
      last_q   <= 1'b0;
      ack_q    <= 1'b0;
      pend_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q     <= st_d;
      flag_q   <= flag_d;
      code_q   <= code_d;
      sh_q     <= sh_d;
      cnt_q    <= cnt_d;
      tmr_q    <= tmr_d;
      sda_dr_q <= sda_dr_d;
      // clock held low while waiting on software in S_HOLD, or after own start
      scl_dr_q <= (st_d == twi_st_pkg::S_HOLD && flag_d) ||
                  st_d == twi_st_pkg::S_MST;
      last_q   <= last_d;
      ack_q    <= ack_d;
      pend_q   <= pend_d;
    end
  end

  // ***********************************
  // software registers
  // ***********************************
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= twi_st_pkg::CTRL_RST;
      data_q <= 8'hff;
      own_q  <= 8'h00;
      mask_q <= 2'h0;
      evt_q  <= 2'h0;
      busy_q <= 1'b0;
      arb_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_q[6:4] <= reg_wdata_i[6:4];
      if (wr_ctrl)
        ctrl_q[twi_st_pkg::CB_EN] <= reg_wdata_i[twi_st_pkg::CB_EN];
      if (stop_clr)
        ctrl_q[twi_st_pkg::CB_STOP] <= 1'b0;
      // data may only change while the flag is up
      if (wr_data)
        ctrl_q[twi_st_pkg::CB_WCOL] <= ~flag_q;
      if (wr_data && flag_q)
        data_q <= reg_wdata_i;
      if (wr_own)
        own_q <= reg_wdata_i;
      if (wr_mask)
        mask_q <= reg_wdata_i[1:0];
      evt_q  <= evt_d;
      busy_q <= ev.start | (busy_q & ~ev.stop);
      arb_q  <= arb_lost_i | (arb_q & ~(st_q == twi_st_pkg::S_AACK && ev.scl_fall));
    end
  end

  // ***********************************
  // outputs, all from flip-flops
  // ***********************************
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
      irq_q   <= |(evt_d & mask_q);
    end
  end
  assign reg_rdata_o = rdata_q;
  assign irq_o       = irq_q;
  assign scl_oe_o    = scl_dr_q;
  assign sda_oe_o    = sda_dr_q;
  assign scl_o       = ctrl_q[1];   // bit 1 never written: constant 0
  assign sda_o       = ctrl_q[0];   // bit 0 never written: constant 0

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_ack_end;
    ce_i && enable && !frame_err && st_q == twi_st_pkg::S_TACK && ev.scl_fall;
  endsequence
  property p_own_read;
    (ce_i && enable && !frame_err && st_q == twi_st_pkg::S_AACK && ev.scl_fall && !arb_q)
      |=> flag_q && code_q == twi_st_pkg::ST_OWN_READ;
  endproperty
  a_own_read: assert property (p_own_read) else $error("own read code wrong");
  property p_arb_read;
    (ce_i && enable && !frame_err && st_q == twi_st_pkg::S_AACK && ev.scl_fall && arb_q)
      |=> flag_q && code_q == twi_st_pkg::ST_ARB_READ;
  endproperty
  a_arb_read: assert property (p_arb_read) else $error("arb read code wrong");
  property p_data_ack;
    (s_ack_end and (ack_q && !last_q)) |=> code_q == twi_st_pkg::ST_DATA_ACK && flag_q;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("ack code wrong");
  property p_nack;
    (s_ack_end and !ack_q) |=> code_q == twi_st_pkg::ST_DATA_NACK;
  endproperty
  a_nack: assert property (p_nack) else $error("nack code wrong");
  property p_last_ack;
    (s_ack_end and (ack_q && last_q)) |=> code_q == twi_st_pkg::ST_LAST_ACK;
  endproperty
  a_last_ack: assert property (p_last_ack) else $error("last ack code wrong");
  property p_no_info;
    (ce_i && reg_rd_i && reg_addr_i == twi_st_pkg::A_STS && !flag_q)
      |=> reg_rdata_o == twi_st_pkg::ST_NO_INFO;
  endproperty
  a_no_info: assert property (p_no_info) else $error("idle status not f8");
  property p_berr;
    (ce_i && frame_err) |=> flag_q && code_q == twi_st_pkg::ST_BUS_ERR && !sda_oe_o;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not flagged");
  property p_recover;
    (ce_i && enable && st_q == twi_st_pkg::S_BERR && flag_clr &&
     reg_wdata_i[twi_st_pkg::CB_STOP])
      |=> st_q == twi_st_pkg::S_IDLE && !ctrl_q[twi_st_pkg::CB_STOP] && !scl_oe_o && !sda_oe_o;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery incomplete");
  property p_stretch;
    (flag_q && st_q == twi_st_pkg::S_HOLD) |-> scl_oe_o;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not stretched");
  property p_msb;
    (ce_i && enable && st_q == twi_st_pkg::S_TX && $past(ce_i) && !ev.scl_fall && !frame_err)
      |=> sda_oe_o == ~sh_q[7];
  endproperty
  a_msb: assert property (p_msb) else $error("data bit wrong");
endmodule : twi_slave_tx

// *** hdl/twi_st_pkg.sv ***
// constants, register map and state type of the slave transmit core
// assumes a 50 MHz reference clock; shared by the core and its bench
package twi_st_pkg;
  // ***********************************
  // status codes, prescaler bits read 0
  // ***********************************
  localparam logic [7:0] ST_OWN_READ  = 8'ha8; // addressed for read
  localparam logic [7:0] ST_ARB_READ  = 8'hb0; // lost arbitration, read
  localparam logic [7:0] ST_DATA_ACK  = 8'hb8; // byte sent, ack back
  localparam logic [7:0] ST_DATA_NACK = 8'hc0; // byte sent, nack back
  localparam logic [7:0] ST_LAST_ACK  = 8'hc8; // last byte, still ack
  localparam logic [7:0] ST_NO_INFO   = 8'hf8; // flag clear
  localparam logic [7:0] ST_BUS_ERR   = 8'h00; // misplaced start/stop
  localparam logic [7:0] PRESC_MASK   = 8'hf8; // low three bits forced 0
  // ***********************************
  // register indices on the plain port
  // ***********************************
  localparam logic [2:0] A_CTRL = 3'h0; // bus_control_register
  localparam logic [2:0] A_STS  = 3'h1; // bus_status_register
  localparam logic [2:0] A_DATA = 3'h2; // bus_data_register
  localparam logic [2:0] A_OWN  = 3'h3; // own_address_register
  localparam logic [2:0] A_EVT  = 3'h4; // sticky events, write 1 clears
  localparam logic [2:0] A_MASK = 3'h5; // event mask
  // ***********************************
  // control, own address and event bit positions
  // ***********************************
  localparam int CB_FLAG  = 7; // operation_complete_flag
  localparam int CB_ACKEN = 6; // acknowledge_enable
  localparam int CB_START = 5; // start_request_bit
  localparam int CB_STOP  = 4; // stop_request_flag
  localparam int CB_WCOL  = 3; // data write while flag clear
  localparam int CB_EN    = 2; // interface enable
  localparam int OWN_GCE  = 0; // general_call_enable in own address
  localparam int EV_DONE  = 0; // event bit: flag raised
  localparam int EV_BERR  = 1; // event bit: bus error
  localparam int EV_W     = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ***********************************
  // timing
  // ***********************************
  localparam int CLK_MHZ     = 50;
  localparam int CLK_NS      = 1000 / CLK_MHZ;
  localparam int T_HD_STA_NS = 4000; // start hold time, least
  localparam logic [7:0] HD_STA_CYC = 8'((T_HD_STA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] BITS = 4'h8; // bits per byte
  // core states
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_HOLD, S_TX, S_TACK, S_BERR, S_GEN, S_MST} st_t;
endpackage : twi_st_pkg

// *** hdl/bus_evt_if.sv ***
// bundle of synchronised line levels and line events
// assumes every member is driven on ref_clk
`timescale 1ns/1ps
interface bus_evt_if;
  logic scl;       // synchronised clock line
  logic sda;       // synchronised data line
  logic scl_rise;  // one-cycle pulse
  logic scl_fall;  // one-cycle pulse
  logic start;     // start condition seen
  logic stop;      // stop condition seen
  modport sync (output scl, sda);
  modport det  (input scl, sda, output scl_rise, scl_fall, start, stop);
  modport core (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : bus_evt_if

// *** hdl/line_sync.sv ***
// two-stage synchroniser for the clock and data lines
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/1ps
module line_sync
(
  // clock
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // synchronised levels
  bus_evt_if.sync   lines
);
  logic [1:0] m_q; // first stage, read only by s_q
  logic [1:0] s_q; // second stage
  // ***********************************
  // synchroniser, idles high like the bus
  // ***********************************
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      m_q <= 2'h3;
      s_q <= 2'h3;
    end
    else if (ce_i)
    begin
      m_q <= {scl_i, sda_i};
      s_q <= m_q;
    end
  end
  assign lines.scl = s_q[1];
  assign lines.sda = s_q[0];
endmodule : line_sync

// *** hdl/line_detect.sv ***
// finds clock edges and start/stop conditions on synchronised lines
// assumes the inputs are already in the ref_clk domain
`timescale 1ns/1ps
module line_detect
(
  // clock
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // levels in, events out
  bus_evt_if.det    ev
);
  logic scl_q; // previous clock level
  logic sda_q; // previous data level
  // ***********************************
  // history of one cycle
  // ***********************************
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_q <= ev.scl;
      sda_q <= ev.sda;
    end
  end
  // data moving while clock high marks start or stop
  assign ev.scl_rise = ce_i & ev.scl & ~scl_q;
  assign ev.scl_fall = ce_i & ~ev.scl & scl_q;
  assign ev.start    = ce_i & ev.scl & scl_q & sda_q & ~ev.sda;
  assign ev.stop     = ce_i & ev.scl & scl_q & ~sda_q & ev.sda;
endmodule : line_detect

// *** verif/twi_master_model.sv ***
// behavioural bus master receiver for the slave transmitter bench
// assumes open-drain lines whose pull-ups are resolved in the bench
`timescale 1ns/1ps
module twi_master_model
(
  // resolved line levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // high pulls the line low
  output logic      scl_low_o,
  output logic      sda_low_o
);
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // one clock: data set while low, stretching waited out, sampled late in high
  // data moves 10 ns after the clock fell, so the two lines never move together
  task automatic bit_x(input logic b, output logic s);
    int n;
    #10 sda_low_o = ~b;
    #70 scl_low_o = 1'b0;
    n = 0;
    // bounded so a stuck clock line cannot hang the model
    while (scl_i !== 1'b1 && n < 5000)
    begin
      #20 n++;
    end
    #76 s = sda_i;
    #4 scl_low_o = 1'b1;
  endtask : bit_x
  // start or repeated start from any line state
  task automatic start_c();
    #10 sda_low_o = 1'b0;
    #70 scl_low_o = 1'b0;
    #80 sda_low_o = 1'b1;
    #80 scl_low_o = 1'b1;
  endtask : start_c
  // stop leaves both lines released
  task automatic stop_c();
    #10 sda_low_o = 1'b1;
    #70 scl_low_o = 1'b0;
    #80 sda_low_o = 1'b0;
    #80;
  endtask : stop_c
  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] o, input logic a, output logic [7:0] i, output logic k);
    for (int j = 7; j >= 0; j--) bit_x(o[j], i[j]);
    bit_x(a, k);
  endtask : xfer
endmodule : twi_master_model

// *** verif/twi_slave_tx_tb.sv ***
// self-checking bench for the two-wire slave transmitter core
// assumes the master receiver model on the far side and pull-ups on both lines
`timescale 1ns/1ps
module twi_slave_tx_tb;
  // register port and control drives
  logic       ref_clk_i = 1'b0;
  logic       reset_i   = 1'b1;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       arb_lost  = 1'b0;
  // design outputs and resolved lines
  logic [7:0] rdata;
  logic       scl_oe, sda_oe, scl_o, sda_o, irq, m_scl, m_sda;
  wire        scl = ~(scl_oe | m_scl);
  wire        sda = ~(sda_oe | m_sda);
  int         n_fail = 0;
  int         n_compared = 0;
  logic [7:0] d;
  logic       k;
  twi_slave_tx uut
  (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(1'b1), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
    .arb_lost_i(arb_lost), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq)
  );
  twi_master_model mst (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
  // comparison with counting
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // lets the flag settle after the ninth falling clock
  task automatic sts(input string nm, input logic [7:0] e);
    repeat (12) @(posedge ref_clk_i);
    rd(twi_st_pkg::A_STS, d);
    chk(nm, d, e);
  endtask : sts
  task automatic t_reset();
    sts("idle", twi_st_pkg::ST_NO_INFO);
    rd(3'h7, d);
    chk("unmapped", d, 8'h00);
    @(posedge ref_clk_i);
    #1 chk("rdata idle", rdata, 8'h00);
    chk("pin levels", {6'h00, scl_o, sda_o}, 8'h00);
    wr(twi_st_pkg::A_OWN, 8'h54);
    wr(twi_st_pkg::A_MASK, 8'h01);
    // switched off: own address must not be acknowledged
    wr(twi_st_pkg::A_CTRL, 8'h40);
    mst.start_c();
    mst.xfer(8'h55, 1'b1, d, k);
    chk("off no ack", {7'h0, k}, 8'h01);
    mst.stop_c();
    // data write with flag clear is refused and marks a collision
    wr(twi_st_pkg::A_DATA, 8'h12);
    rd(twi_st_pkg::A_CTRL, d);
    chk("collision", d, 8'h48);
    rd(twi_st_pkg::A_DATA, d);
    chk("data kept", d, 8'hff);
    wr(twi_st_pkg::A_CTRL, 8'h44);
  endtask : t_reset
  task automatic t_last();
    mst.start_c();
    mst.xfer(8'h55, 1'b1, d, k);
    chk("addr ack", {7'h0, k}, 8'h00);
    sts("own read", twi_st_pkg::ST_OWN_READ);
    chk("stretch", {7'h0, scl_oe}, 8'h01);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(twi_st_pkg::A_EVT, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    chk("irq clear", {7'h0, irq}, 8'h00);
    wr(twi_st_pkg::A_DATA, 8'ha5);
    wr(twi_st_pkg::A_CTRL, 8'hc4);
    mst.xfer(8'hff, 1'b0, d, k);
    chk("msb first", d, 8'ha5);
    sts("data ack", twi_st_pkg::ST_DATA_ACK);
    wr(twi_st_pkg::A_DATA, 8'h3c);
    wr(twi_st_pkg::A_CTRL, 8'h84);
    mst.xfer(8'hff, 1'b0, d, k);
    chk("last byte", d, 8'h3c);
    sts("last acked", twi_st_pkg::ST_LAST_ACK);
    wr(twi_st_pkg::A_CTRL, 8'ha4);
    mst.xfer(8'hff, 1'b0, d, k);
    chk("all ones", d, 8'hff);
    mst.stop_c();
    for (int n = 0; n < 300 && sda_oe !== 1'b1; n++) @(posedge ref_clk_i);
    chk("start sda", {7'h0, sda_oe}, 8'h01);
    chk("start scl", {7'h0, scl_oe}, 8'h00);
    repeat (210) @(posedge ref_clk_i);
    chk("start hold", {7'h0, scl_oe}, 8'h01);
    wr(twi_st_pkg::A_CTRL, 8'h44);
  endtask : t_last
  task automatic t_berr();
    mst.start_c();
    repeat (3) mst.bit_x(1'b1, k);
    mst.start_c();
    sts("bus error", twi_st_pkg::ST_BUS_ERR);
    chk("no stretch", {7'h0, scl_oe}, 8'h00);
    chk("sda released", {7'h0, sda_oe}, 8'h00);
    wr(twi_st_pkg::A_CTRL, 8'hd4);
    rd(twi_st_pkg::A_CTRL, d);
    chk("stop cleared", d, 8'h44);
    sts("recovered", twi_st_pkg::ST_NO_INFO);
    mst.stop_c();
  endtask : t_berr
  task automatic t_arb();
    @(posedge ref_clk_i);
    arb_lost <= 1'b1;
    @(posedge ref_clk_i);
    arb_lost <= 1'b0;
    mst.start_c();
    mst.xfer(8'h55, 1'b1, d, k);
    sts("arb read", twi_st_pkg::ST_ARB_READ);
    wr(twi_st_pkg::A_DATA, 8'h81);
    wr(twi_st_pkg::A_CTRL, 8'hc4);
    mst.xfer(8'hff, 1'b1, d, k);
    chk("arb byte", d, 8'h81);
    sts("nack", twi_st_pkg::ST_DATA_NACK);
    wr(twi_st_pkg::A_CTRL, 8'h84);
    mst.stop_c();
    mst.start_c();
    mst.xfer(8'h55, 1'b1, d, k);
    chk("ignored", {7'h0, k}, 8'h01);
    mst.stop_c();
  endtask : t_arb
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_last();
    t_berr();
    t_arb();
    report_and_stop();
  end
  // watchdog well past the expected run of a few tens of microseconds
  initial
  begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
endmodule : twi_slave_tx_tb
